// [rtl/fixed_priority_irq_unit.sv]
`timescale 1ns/100ps

// Functional notes
// RQ1: Four maskable sources plus one non-maskable.
// RQ2: Each source has a fixed vector slot.
// RQ3: Accepted request loads its vector into PC.
// RQ4: NMI preempts all; maskables never nest.
// RQ5: Pending maskables served source one first.
// RQ6: Global enable masks sources and gates wake.
// RQ7: NMI latched, cleared when its routine starts.
// RQ8: Source one level or falling edge selectable.
// RQ9: Source two edge, polarity selectable.
// RQ10: Sources three and four level only.
// RQ11: Edge latch holds one, cleared on entry.
// RQ12: Level requests sampled low, never stored.
// RQ13: Requests tested at each instruction end.
// RQ14: Separate flag pairs swapped in on entry.
// RQ15: Entry pushes PC, inhibits maskables, loads vector.
// RQ16: Return restores flag pair and pops PC.
// RQ17: Zeroing option load skips flag pair swap; code skips it on maskable entry only, NMI entry still swaps.
// RQ18: Shared-line events keep pollable sticky flags.
// RQ19: Reset starts in NMI mode until return.
// RQ20: Option register write-only, no bit ops, resets zero.
module fixed_priority_irq_unit #(
    parameter int EVT_N = 2
) (
    input  wire logic                    clk_i,        // Core clock, 250 MHz
    input  wire logic                    rst_i,        // Async reset, active high
    input  wire logic                    nmi_n_i,      // NMI pin, falling edge
    input  wire logic [4:1]              src_n_i,      // Source lines, active low
    input  wire logic [EVT_N-1:0]        evt_i,        // Events shared on source 3
    input  wire logic [EVT_N-1:0]        evt_clr_i,    // Clear event flags
    input  wire irq_unit_pkg::opt_wr_s   opt_i,        // Option register write
    input  wire logic                    instr_end_i,  // Instruction completes
    input  wire logic                    load_immediate_op_i, // Zeroing option load running
    input  wire logic                    return_from_irq_i,   // Return from interrupt
    input  wire logic                    sleep_i,      // Core in stop or wait
    input  wire logic                    flag_we_i,    // Update current flags
    input  wire irq_unit_pkg::flag_pair_s flag_i,      // New flag values
    output irq_unit_pkg::entry_s         entry_o,      // Entry request to core
    output logic                         push_pc_o,    // Push PC to stack
    output logic                         pop_pc_o,     // Pop PC from stack
    output irq_unit_pkg::flag_pair_s     flag_o,       // Active flag pair
    output irq_unit_pkg::mode_e          mode_o,       // Core mode
    output logic                         wake_o,       // Leave stop or wait
    output logic [EVT_N-1:0]             evt_flag_o    // Pollable event flags
);

    // ==========================================================
    // Vector and priority helpers

    function automatic logic [11:0] vec_of(input logic [2:0] src);
        unique case (src)
            3'h0:    vec_of = irq_unit_pkg::VEC_SRC0;
            3'h1:    vec_of = irq_unit_pkg::VEC_SRC1;
            3'h2:    vec_of = irq_unit_pkg::VEC_SRC2;
            3'h3:    vec_of = irq_unit_pkg::VEC_SRC3;
            default: vec_of = irq_unit_pkg::VEC_SRC4;
        endcase
    endfunction

    function automatic logic [2:0] pick(input logic [4:1] req);
        pick = 3'h0;
        for (int i = 4; i >= 1; i--) begin
            if (req[i]) begin
                pick = 3'(i);
            end
        end
    endfunction

    // ==========================================================
    // State

    typedef struct packed {
        logic [7:0]                opt;
        irq_unit_pkg::mode_e       mode;
        irq_unit_pkg::mode_e       nmi_ret_mode;
        irq_unit_pkg::mode_e       sel;
        irq_unit_pkg::mode_e       nmi_ret_sel;
        irq_unit_pkg::flag_pair_s  pair_n;
        irq_unit_pkg::flag_pair_s  pair_i;
        irq_unit_pkg::flag_pair_s  pair_m;
        logic [EVT_N-1:0]          evt;
        logic                      take;
        logic                      nmi;
        logic [11:0]               vector;
        logic                      pop;
        logic                      wake;
    } unit_s;

    unit_s st;
    unit_s next_st;

    // ==========================================================
    // Pin synchronisation

    logic [4:0] line_raw;
    logic [4:0] line;

    assign line_raw = {src_n_i, nmi_n_i};

    irq_pin_sync #(
        .W (irq_unit_pkg::NUM_LINES)
    ) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .line_i (line_raw),
        .line_o (line)
    );

    // ==========================================================
    // Option bits

    logic global_irq_enable;
    logic src2_polarity_select;
    logic src1_level_select;

    assign global_irq_enable    = st.opt[irq_unit_pkg::OPT_GLOBAL_EN];
    assign src2_polarity_select = st.opt[irq_unit_pkg::OPT_SRC2_POLARITY];
    assign src1_level_select    = st.opt[irq_unit_pkg::OPT_SRC1_LEVEL];

    // ==========================================================
    // Option register write

    logic opt_hit;

    // Write-only register; single-bit operations are refused
    assign opt_hit = opt_i.wr & ~opt_i.bit_op
                     & (opt_i.addr == irq_unit_pkg::OPT_ADDR);         // RQ20

    // ==========================================================
    // Edge latches

    logic       take_nmi;
    logic [4:1] take_src;
    logic       nmi_pend;
    logic       src1_pend;
    logic       src2_pend;
    logic       src1_clr;

    assign src1_clr = take_src[1] | src1_level_select;

    irq_edge_latch u_nmi_latch (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .line_i (line[0]),
        .rise_i (1'b0),
        .clr_i  (take_nmi),                             // RQ7
        .pend_o (nmi_pend)
    );

    irq_edge_latch u_src1_latch (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .line_i (line[1]),
        .rise_i (1'b0),                                 // RQ8
        .clr_i  (src1_clr),
        .pend_o (src1_pend)
    );

    irq_edge_latch u_src2_latch (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .line_i (line[2]),
        .rise_i (src2_polarity_select),                 // RQ9
        .clr_i  (take_src[2]),
        .pend_o (src2_pend)
    );

    // ==========================================================
    // Request collection

    logic [4:1] req;
    logic [4:1] req_en;
    logic [2:0] win;
    logic       accept;

    always_comb begin
        req[1] = src1_level_select ? ~line[1] : src1_pend;     // RQ8
        req[2] = src2_pend;                                    // RQ9
        req[3] = ~line[3] | (|st.evt);                         // RQ10 RQ12 RQ18
        req[4] = ~line[4];                                     // RQ10 RQ12
    end

    // Maskables only from normal mode, so none nests in another
    assign req_en = (global_irq_enable && st.mode == irq_unit_pkg::MODE_NORMAL)
                    ? req : 4'h0;                              // RQ4 RQ6

    assign win = pick(req_en);                                 // RQ5

    // NMI outranks all and preempts any routine but its own
    assign take_nmi = instr_end_i & nmi_pend
                      & (st.mode != irq_unit_pkg::MODE_NMI);   // RQ4 RQ13

    assign accept = instr_end_i & ~take_nmi & (|req_en);       // RQ13

    always_comb begin
        take_src = 4'h0;
        if (accept) begin
            take_src[win] = 1'b1;
        end
    end

    // ==========================================================
    // Wake sources

    logic wake_any;

    // Global enable gates every source, the non-maskable one too
    assign wake_any = global_irq_enable & (nmi_pend | (|req));         // RQ6

    // ==========================================================
    // Shared-line event flags

    logic [EVT_N-1:0] evt_merge;

    // A new event wins over a clear in the same cycle
    assign evt_merge = evt_i | (st.evt & ~evt_clr_i);                  // RQ18

    // ==========================================================
    // Entry selection

    logic [11:0]         entry_vec;
    irq_unit_pkg::mode_e entry_sel;

    // A zeroing option load in flight leaves the normal pair active on a maskable entry
    always_comb begin
        entry_vec = vec_of(win);                                       // RQ1 RQ2 RQ3
        entry_sel = load_immediate_op_i ? irq_unit_pkg::MODE_NORMAL
                                        : irq_unit_pkg::MODE_IRQ;      // RQ14 RQ17
        if (take_nmi) begin
            entry_vec = vec_of(3'h0);                                  // RQ2 RQ3
            entry_sel = irq_unit_pkg::MODE_NMI;                        // RQ14
        end
    end

    // ==========================================================
    // Return path

    irq_unit_pkg::mode_e ret_mode;
    irq_unit_pkg::mode_e ret_sel;

    // A return from normal mode keeps the mode and still pops
    always_comb begin
        ret_mode = st.mode;
        ret_sel  = st.sel;
        unique case (st.mode)
            irq_unit_pkg::MODE_NMI: begin
                ret_mode = st.nmi_ret_mode;
                ret_sel  = st.nmi_ret_sel;                             // RQ19
            end
            irq_unit_pkg::MODE_IRQ: begin
                ret_mode = irq_unit_pkg::MODE_NORMAL;
                ret_sel  = irq_unit_pkg::MODE_NORMAL;
            end
            default: ret_mode = st.mode;
        endcase
    end

    // ==========================================================
    // Next state

    always_comb begin
        next_st      = st;
        next_st.take = 1'b0;
        next_st.nmi  = 1'b0;
        next_st.pop  = 1'b0;

        if (opt_hit) begin
            next_st.opt = opt_i.data;                          // RQ20
        end

        next_st.evt = evt_merge;                               // RQ18

        // Flag update goes to the active pair
        if (flag_we_i) begin
            unique case (st.sel)
                irq_unit_pkg::MODE_NORMAL: next_st.pair_n = flag_i;
                irq_unit_pkg::MODE_IRQ:    next_st.pair_i = flag_i;
                default:                   next_st.pair_m = flag_i;
            endcase
        end

        if (take_nmi) begin
            next_st.take         = 1'b1;                       // RQ15
            next_st.nmi          = 1'b1;
            next_st.vector       = entry_vec;                  // RQ3
            next_st.nmi_ret_mode = st.mode;
            next_st.nmi_ret_sel  = st.sel;
            next_st.mode         = irq_unit_pkg::MODE_NMI;
            next_st.sel          = entry_sel;                  // RQ14
        end else if (accept) begin
            next_st.take   = 1'b1;                             // RQ15
            next_st.vector = entry_vec;                        // RQ3
            next_st.mode   = irq_unit_pkg::MODE_IRQ;
            next_st.sel    = entry_sel;                        // RQ14 RQ17
        end else if (return_from_irq_i) begin
            next_st.pop  = 1'b1;                               // RQ16
            next_st.mode = ret_mode;                           // RQ16
            next_st.sel  = ret_sel;                            // RQ16
        end

        next_st.wake = sleep_i & wake_any;                     // RQ6
    end

    // ==========================================================
    // Registers

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st              <= '0;
            st.opt          <= irq_unit_pkg::OPT_RESET;        // RQ20
            st.mode         <= irq_unit_pkg::MODE_NMI;         // RQ19
            st.sel          <= irq_unit_pkg::MODE_NMI;
            st.nmi_ret_mode <= irq_unit_pkg::MODE_NORMAL;
            st.nmi_ret_sel  <= irq_unit_pkg::MODE_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs

    assign entry_o.take   = st.take;
    assign entry_o.nmi    = st.nmi;
    assign entry_o.vector = st.vector;
    assign push_pc_o      = st.take;                           // RQ15
    assign pop_pc_o       = st.pop;
    assign mode_o         = st.mode;
    assign wake_o         = st.wake;
    assign evt_flag_o     = st.evt;

    // ==========================================================
    // Active flag pair

    // Reads follow the selection, so a skipped swap shows the normal pair
    always_comb begin
        unique case (st.sel)
            irq_unit_pkg::MODE_NORMAL: flag_o = st.pair_n;
            irq_unit_pkg::MODE_IRQ:    flag_o = st.pair_i;
            default:                   flag_o = st.pair_m;
        endcase
    end

endmodule

// [rtl/irq_edge_latch.sv]
`timescale 1ns/100ps

module irq_edge_latch (
    input  wire logic clk_i,     // Core clock
    input  wire logic rst_i,     // Async reset, active high
    input  wire logic line_i,    // Synchronised line level
    input  wire logic rise_i,    // 1: rising edge, 0: falling edge
    input  wire logic clr_i,     // Service routine starts
    output logic      pend_o     // Stored request
);

    // ==========================================================
    // State
    typedef struct packed {
        logic prev;
        logic pend;
    } edge_s;

    edge_s st;
    edge_s next_st;
    logic  hit;

    // ==========================================================
    // One occurrence held; a new edge wins over the clear
    always_comb begin
        next_st      = st;
        hit          = rise_i ? (line_i & ~st.prev) : (~line_i & st.prev);
        next_st.prev = line_i;
        next_st.pend = hit | (st.pend & ~clr_i);    // RQ11
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{prev: irq_unit_pkg::LINE_IDLE, pend: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pend_o = st.pend;

endmodule

// [rtl/irq_pin_sync.sv]
`timescale 1ns/100ps

module irq_pin_sync #(
    parameter int W = 5
) (
    input  wire logic         clk_i,     // Core clock
    input  wire logic         rst_i,     // Async reset, active high
    input  wire logic [W-1:0] line_i,    // Raw pin levels
    output logic      [W-1:0] line_o     // Filtered levels
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // ==========================================================
    // A change counts only once stages two and three agree
    always_comb begin
        next_st    = st;
        next_st.s1 = line_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.stable[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= {4*W{irq_unit_pkg::LINE_IDLE}};
        end else begin
            st <= next_st;
        end
    end

    assign line_o = st.stable;

endmodule

// [rtl/irq_unit_pkg.sv]
package irq_unit_pkg;

    // ==========================================================
    // Vector slots (first byte of each two-byte slot)
    localparam int          VEC_W      = 12;
    localparam logic [11:0] VEC_SRC0   = 12'hffc;
    localparam logic [11:0] VEC_SRC1   = 12'hff6;
    localparam logic [11:0] VEC_SRC2   = 12'hff4;
    localparam logic [11:0] VEC_SRC3   = 12'hff2;
    localparam logic [11:0] VEC_SRC4   = 12'hff0;

    // ==========================================================
    // Option register layout
    localparam logic [7:0]  OPT_ADDR   = 8'hc8;
    localparam logic [7:0]  OPT_RESET  = 8'h00;
    localparam int          OPT_SRC1_LEVEL    = 6;
    localparam int          OPT_SRC2_POLARITY = 5;
    localparam int          OPT_GLOBAL_EN     = 4;

    // ==========================================================
    // Idle level of request lines (active low)
    localparam logic        LINE_IDLE  = 1'b1;
    localparam int          NUM_LINES  = 5;

    // ==========================================================
    // Modes and flag pairs
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_IRQ,
        MODE_NMI
    } mode_e;

    typedef struct packed {
        logic carry;
        logic zero;
    } flag_pair_s;

    typedef struct packed {
        logic              take;
        logic              nmi;
        logic [VEC_W-1:0]  vector;
    } entry_s;

    typedef struct packed {
        logic       wr;
        logic       bit_op;
        logic [7:0] addr;
        logic [7:0] data;
    } opt_wr_s;

endpackage

// [test/core_seq_model.sv]
`timescale 1ns/100ps
// ========================================
// Instruction sequencer of the core
module core_seq_model (
    input  wire logic clk_i,   // Clock
    input  wire logic rst_i,   // Reset
    input  wire logic sleep_i, // Core asleep
    input  int        gap_i,   // Cycles per instruction
    output logic      end_o    // Instruction boundary
);
    int cnt;

    // No boundaries while asleep
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            end_o <= 1'b0;
        end else begin
            cnt <= (sleep_i || cnt + 1 >= gap_i) ? 0 : cnt + 1;
            end_o <= !sleep_i && cnt + 1 >= gap_i;
        end
    end
endmodule

// [test/irq_unit_props.sv]
`timescale 1ns/100ps
// ========================================
// Port checker
module irq_unit_props #(
    parameter int EVT_N = 2
) (
    input wire logic                 clk_i,       // Clock
    input wire logic                 rst_i,       // Reset
    input wire logic                 instr_end_i, // Boundary
    input wire logic                 return_from_irq_i, // Return
    input wire logic                 sleep_i,     // Asleep
    input wire logic [EVT_N-1:0]     evt_i,       // Events
    input wire irq_unit_pkg::entry_s entry_o,     // Entry
    input wire logic                 push_pc_o,   // Push
    input wire logic                 pop_pc_o,    // Pop
    input wire irq_unit_pkg::mode_e  mode_o,      // Mode
    input wire logic                 wake_o,      // Wake
    input wire logic [EVT_N-1:0]     evt_flag_o   // Flags
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ret;
        return_from_irq_i && mode_o == irq_unit_pkg::MODE_IRQ && !instr_end_i;
    endsequence
    sequence s_back;
        pop_pc_o && mode_o == irq_unit_pkg::MODE_NORMAL;
    endsequence

    a_push_with_take: assert property ((push_pc_o == entry_o.take)
        && !(push_pc_o && mode_o == irq_unit_pkg::MODE_NORMAL))
        else $error("push differs from entry");
    a_take_at_end: assert property (entry_o.take |-> $past(instr_end_i))
        else $error("entry without boundary");
    a_nmi_vector: assert property (entry_o.take && entry_o.nmi |->
        entry_o.vector == irq_unit_pkg::VEC_SRC0 && mode_o == irq_unit_pkg::MODE_NMI)
        else $error("bad nmi entry");
    a_no_nesting: assert property (entry_o.take && !entry_o.nmi |->
        $past(mode_o) == irq_unit_pkg::MODE_NORMAL && mode_o == irq_unit_pkg::MODE_IRQ)
        else $error("maskable entry nested");
    a_ret_restores: assert property (s_ret |=> s_back)
        else $error("return did not restore");
    a_pop_cause: assert property (pop_pc_o |-> $past(return_from_irq_i))
        else $error("pop without return");
    a_nmi_holds: assert property (mode_o == irq_unit_pkg::MODE_NMI && !return_from_irq_i |=>
        mode_o == irq_unit_pkg::MODE_NMI)
        else $error("left nmi mode");
    a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
        else $error("wake while awake");
    a_evt_sticky: assert property (evt_i[0] |=> evt_flag_o[0])
        else $error("event flag missed");
endmodule

bind fixed_priority_irq_unit irq_unit_props #(.EVT_N(EVT_N)) u_irq_unit_props (
    .clk_i, .rst_i, .instr_end_i, .return_from_irq_i, .sleep_i, .evt_i,
    .entry_o, .push_pc_o, .pop_pc_o, .mode_o, .wake_o, .evt_flag_o);

// [test/testbench.sv]
`timescale 1ns/100ps
// ========================================
// Bench
module testbench;
    localparam irq_unit_pkg::mode_e NRM = irq_unit_pkg::MODE_NORMAL;
    localparam irq_unit_pkg::mode_e IRQ = irq_unit_pkg::MODE_IRQ;
    localparam irq_unit_pkg::mode_e NMI = irq_unit_pkg::MODE_NMI;
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     nmi_n_i = 1'b1;
    logic [4:1]               src_n_i = 4'hf;
    logic [1:0]               evt_i = 2'h0;
    logic [1:0]               evt_clr_i = 2'h0;
    irq_unit_pkg::opt_wr_s    opt_i = 18'h0;
    logic                     load_immediate_op_i = 1'b0;
    logic                     return_from_irq_i = 1'b0;
    logic                     sleep_i = 1'b0;
    logic                     flag_we_i = 1'b0;
    irq_unit_pkg::flag_pair_s flag_i = 2'h0;
    irq_unit_pkg::entry_s     entry_o;
    irq_unit_pkg::flag_pair_s flag_o;
    irq_unit_pkg::mode_e      mode_o;
    logic                     instr_end_i, push_pc_o, pop_pc_o, wake_o;
    logic [1:0]               evt_flag_o;
    logic [11:0]              vtab [5] = '{12'hffc, 12'hff6, 12'hff4, 12'hff2, 12'hff0};
    logic [3:0]               m;
    int                       gap = 4, n_fail = 0, checks = 0, k;
    int                       q [$];

    always #2 clk_i = ~clk_i;

    fixed_priority_irq_unit #(.EVT_N(2)) u_fixed_priority_irq_unit (
        .clk_i, .rst_i, .nmi_n_i, .src_n_i, .evt_i, .evt_clr_i, .opt_i, .instr_end_i,
        .load_immediate_op_i, .return_from_irq_i, .sleep_i, .flag_we_i, .flag_i, .entry_o,
        .push_pc_o, .pop_pc_o, .flag_o, .mode_o, .wake_o, .evt_flag_o);
    core_seq_model u_core_seq_model (.clk_i, .rst_i, .sleep_i, .gap_i(gap), .end_o(instr_end_i));

    // ========================================
    // Tasks
    task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask
    task automatic cmp_mode(input irq_unit_pkg::mode_e got, input irq_unit_pkg::mode_e exp);
        cmp_word({10'h0, got}, {10'h0, exp}, "mode");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic src(input logic [3:0] v);
        @(posedge clk_i);
        src_n_i <= v;
    endtask
    task automatic wr_opt(input logic [7:0] d, input logic b, input logic [7:0] a);
        @(posedge clk_i);
        opt_i <= '{1'b1, b, a, d};
        @(posedge clk_i);
        opt_i <= 18'h0;
    endtask
    task automatic wflag(input logic [1:0] f);
        @(posedge clk_i);
        flag_we_i <= 1'b1;
        flag_i <= f;
        @(posedge clk_i);
        flag_we_i <= 1'b0;
    endtask
    task automatic ret_chk(input irq_unit_pkg::mode_e md);
        @(posedge clk_i);
        return_from_irq_i <= 1'b1;
        @(posedge clk_i);
        return_from_irq_i <= 1'b0;
        @(negedge clk_i);
        cmp_word({11'h0, pop_pc_o}, 12'h1, "pop");
        cmp_mode(mode_o, md);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk_i);
            cmp_word({11'h0, entry_o.take}, 12'h0, "stray entry");
        end
    endtask
    task automatic take(input int s);
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge clk_i);
            if (entry_o.take === 1'b1)
                break;
        end
        if (i == 60) begin
            n_fail++;
            $display("unexpected at %0t: no entry", $time);
            give_verdict();
        end else begin
            cmp_word(entry_o.vector, vtab[s], "vector");
            cmp_word({11'h0, entry_o.nmi}, {11'h0, s == 0}, "nmi");
            cmp_word({11'h0, push_pc_o}, 12'h1, "push");
            cmp_mode(mode_o, s == 0 ? NMI : IRQ);
        end
    endtask

    // ========================================
    // Scenarios
    initial begin
        void'($urandom(81));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        cmp_mode(mode_o, NMI);
        cmp_word({10'h0, flag_o}, 12'h0, "reset flags");
        src(4'h7);
        ret_chk(NRM);
        wflag(2'h3);
        quiet(12);
        wr_opt(8'h10, 1'b1, 8'hc8);
        wr_opt(8'h10, 1'b0, 8'hc9);
        quiet(12);
        wr_opt(8'h10, 1'b0, 8'hc8);
        take(4);
        wflag(2'h1);
        quiet(12);
        src(4'hf);
        quiet(6);
        ret_chk(NRM);
        cmp_word({10'h0, flag_o}, 12'h3, "normal pair");
        src(4'h7);
        take(4);
        cmp_word({10'h0, flag_o}, 12'h1, "irq pair");
        src(4'hf);
        quiet(6);
        ret_chk(NRM);
        $display("test basic done");
        gap = 9;
        wr_opt(8'h40, 1'b0, 8'hc8);
        repeat (6) begin
            m = 4'($urandom_range(15, 1));
            src(~m);
            quiet(6);
            for (k = 1; k <= 4; k++)
                if (m[k-1])
                    q.push_back(k);
            wr_opt(8'h50, 1'b0, 8'hc8);
            while (q.size() > 0) begin
                k = q.pop_front();
                take(k);
                src(src_n_i | 4'(1 << (k - 1)));
                quiet(6);
                ret_chk(NRM);
            end
            wr_opt(8'h40, 1'b0, 8'hc8);
        end
        gap = 4;
        $display("test priority done");
        wr_opt(8'h20, 1'b0, 8'hc8);
        repeat (2) begin
            src(4'hc);
            quiet(4);
            src(4'hd);
            quiet(4);
        end
        wr_opt(8'h30, 1'b0, 8'hc8);
        take(1);
        quiet(6);
        ret_chk(NRM);
        quiet(20);
        src(4'hf);
        take(2);
        quiet(6);
        ret_chk(NRM);
        $display("test edges done");
        src(4'h7);
        take(4);
        @(posedge clk_i);
        nmi_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        nmi_n_i <= 1'b1;
        take(0);
        quiet(10);
        ret_chk(IRQ);
        src(4'hf);
        quiet(6);
        ret_chk(NRM);
        wr_opt(8'h20, 1'b0, 8'hc8);
        @(posedge clk_i);
        nmi_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        nmi_n_i <= 1'b1;
        take(0);
        ret_chk(NRM);
        $display("test nmi done");
        @(posedge clk_i);
        sleep_i <= 1'b1;
        src(4'h7);
        repeat (8) @(negedge clk_i);
        cmp_word({11'h0, wake_o}, 12'h0, "wake masked");
        wr_opt(8'h30, 1'b0, 8'hc8);
        repeat (3) @(negedge clk_i);
        cmp_word({11'h0, wake_o}, 12'h1, "wake");
        @(posedge clk_i);
        sleep_i <= 1'b0;
        take(4);
        src(4'hf);
        quiet(6);
        ret_chk(NRM);
        $display("test wake done");
        @(posedge clk_i);
        evt_i <= 2'h3;
        @(posedge clk_i);
        evt_i <= 2'h0;
        @(negedge clk_i);
        cmp_word({10'h0, evt_flag_o}, 12'h3, "event flag");
        take(3);
        @(posedge clk_i);
        evt_clr_i <= 2'h3;
        @(posedge clk_i);
        evt_clr_i <= 2'h0;
        @(negedge clk_i);
        cmp_word({10'h0, evt_flag_o}, 12'h0, "event clear");
        quiet(6);
        ret_chk(NRM);
        $display("test events done");
        @(posedge clk_i);
        load_immediate_op_i <= 1'b1;
        src(4'h7);
        take(4);
        cmp_word({10'h0, flag_o}, 12'h3, "kept pair");
        @(posedge clk_i);
        load_immediate_op_i <= 1'b0;
        src(4'hf);
        quiet(6);
        ret_chk(NRM);
        $display("test anomaly done");
        give_verdict();
    end
endmodule
